/* ascpm_device.sv */
// Summary of operation
// - select bits 01 quick, 10 low current
// - select bits 11 keep normal full power
// - host clock at most 4.8MHz in sleeps
// - host transmit/receive clocks tied to link clock
// - host lowers chip select before shifting bits
// - control byte 1xxxxx11 starts conversion, normal
// - strobe falling edge marks result bits ready
// - host captures bits on next 16 rises
// - twelve result bits then four discarded trailing
// - chip select high ends the frame
// - results are plain binary codes
// - select bits 00 mean deep sleep
// - first high bit with select low starts
// - strobe high one clock after control byte
// - sleep applies after conversion, until next byte
`timescale 1ns/1ps
module ascpm_device (
	input  wire logic                         SYS_CLK,
	input  wire logic                         RST_N,
	input  wire logic                         CLK_EN,
	input  wire logic [ascpm_pkg::RESULT_BITS-1:0] SAMPLE_DATA,
	ascpm_if.device                           LINK,
	output logic      [1:0]                   POWER_MODE,
	output logic      [ascpm_pkg::CFG_BITS-1:0] CHANNEL_CONFIG,
	output logic                              FULL_POWER,
	output logic                              QUICK_SLEEP,
	output logic                              LOW_CURRENT_IDLE,
	output logic                              DEEP_SLEEP,
	output logic                              CONVERTING,
	output logic                              CONV_START,
	output logic                              CONV_DONE
);

	// ----------------------------------------
	// link-side state, clocked by the link clock
	// ----------------------------------------
	typedef enum logic [3:0] {
		L_IDLE   = 4'h1,
		L_CTRL   = 4'h2,
		L_STROBE = 4'h4,
		L_SHIFT  = 4'h8
	} ascpm_link_t;

	ascpm_link_t                          link_state_reg;
	logic [4:0]                           bit_cnt_reg;
	logic [ascpm_pkg::CTRL_BITS-1:0]      ctrl_reg;
	logic [ascpm_pkg::READ_BITS-1:0]      out_shift_reg;
	logic                                 started_reg;
	logic                                 done_reg;
	logic                                 dout_reg;
	logic                                 strobe_reg;

	// ----------------------------------------
	// system-side state
	// ----------------------------------------
	logic [ascpm_pkg::RESULT_BITS-1:0]    hold_reg;
	logic [2:0]                           sync_q;
	logic                                 cs_hi_s;
	logic                                 started_s;
	logic                                 done_s;
	logic                                 started_prev_reg;
	logic                                 done_prev_reg;
	logic                                 start_rise;
	logic                                 done_rise;
	logic [1:0]                           mode_reg;
	logic [1:0]                           mode_next;
	logic [1:0]                           pending_reg;
	logic [ascpm_pkg::CFG_BITS-1:0]       cfg_reg;
	logic                                 converting_reg;
	logic                                 start_pulse_reg;
	logic                                 done_pulse_reg;
	logic [3:0]                           flags_reg;

	// ----------------------------------------
	// control byte receive and result shift
	// ----------------------------------------
	// chip select high ends the frame and clears all frame state
	always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
		if (LINK.cs_n) begin
			link_state_reg <= L_IDLE;
			bit_cnt_reg    <= 5'h00;
			ctrl_reg       <= 8'h00;
			out_shift_reg  <= 16'h0000;
			started_reg    <= 1'b0;
			done_reg       <= 1'b0;
		end else begin
			unique case (link_state_reg)
				L_IDLE: begin
					if (LINK.din) begin
						ctrl_reg       <= 8'h01;
						bit_cnt_reg    <= 5'h01;
						link_state_reg <= L_CTRL;
					end
				end
				L_CTRL: begin
					ctrl_reg    <= {ctrl_reg[ascpm_pkg::CTRL_BITS-2:0], LINK.din};
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'(ascpm_pkg::CTRL_BITS - 1)) begin
						// hold_reg is frozen while chip select is low
						out_shift_reg  <= {hold_reg, {ascpm_pkg::TRAIL_BITS{1'b0}}};
						started_reg    <= 1'b1;
						bit_cnt_reg    <= 5'h00;
						link_state_reg <= L_STROBE;
					end
				end
				L_STROBE: begin
					link_state_reg <= L_SHIFT;
				end
				L_SHIFT: begin
					out_shift_reg <= {out_shift_reg[ascpm_pkg::READ_BITS-2:0], 1'b0};
					bit_cnt_reg   <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'(ascpm_pkg::RESULT_BITS - 1)) begin
						done_reg <= 1'b1;
					end
					if (bit_cnt_reg == 5'(ascpm_pkg::READ_BITS - 1)) begin
						link_state_reg <= L_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin drivers, updated on the falling edge
	// ----------------------------------------
	always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
		if (LINK.cs_n) begin
			dout_reg   <= 1'b0;
			strobe_reg <= 1'b0;
		end else begin
			dout_reg   <= (link_state_reg == L_SHIFT) & out_shift_reg[ascpm_pkg::READ_BITS-1];
			strobe_reg <= (link_state_reg == L_STROBE);
		end
	end

	assign LINK.dout        = dout_reg;
	assign LINK.strobe      = strobe_reg;
	assign LINK.dout_oe_n   = LINK.cs_n;
	assign LINK.strobe_oe_n = LINK.cs_n;

	// ----------------------------------------
	// crossing into the system clock
	// ----------------------------------------
	ascpm_sync #(
		.W    (3),
		.INIT (3'h1)
	) u_sync (
		.clk    (SYS_CLK),
		.rst_n  (RST_N),
		.clk_en (CLK_EN),
		.d      ({done_reg, started_reg, LINK.cs_n}),
		.q      (sync_q)
	);

	assign cs_hi_s    = sync_q[0];
	assign started_s  = sync_q[1];
	assign done_s     = sync_q[2];
	assign start_rise = started_s & ~started_prev_reg;
	assign done_rise  = done_s & ~done_prev_reg;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			started_prev_reg <= 1'b0;
			done_prev_reg    <= 1'b0;
		end else if (CLK_EN) begin
			started_prev_reg <= started_s;
			done_prev_reg    <= done_s;
		end
	end

	// sample word only changes between frames
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			hold_reg <= 12'h000;
		end else if (CLK_EN && cs_hi_s) begin
			hold_reg <= SAMPLE_DATA;
		end
	end

	// ----------------------------------------
	// power mode tracking
	// ----------------------------------------
	always_comb begin
		mode_next = mode_reg;
		if (done_rise) begin
			mode_next = pending_reg;
		end else if (start_rise) begin
			mode_next = ascpm_pkg::PWR_NORMAL;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mode_reg       <= ascpm_pkg::PWR_RESET;
			pending_reg    <= ascpm_pkg::PWR_RESET;
			cfg_reg        <= ascpm_pkg::CFG_RESET;
			converting_reg <= 1'b0;
		end else if (CLK_EN) begin
			mode_reg <= mode_next;
			if (start_rise) begin
				pending_reg    <= {ctrl_reg[ascpm_pkg::CTRL_PDH_POS], ctrl_reg[ascpm_pkg::CTRL_PDL_POS]};
				cfg_reg        <= ctrl_reg[ascpm_pkg::CTRL_CFG_LSB +: ascpm_pkg::CFG_BITS];
				converting_reg <= 1'b1;
			end else if (done_rise) begin
				converting_reg <= 1'b0;
			end
		end
	end

	// decoded mode flags: normal, quick, low current, deep
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			flags_reg <= 4'h1;
		end else if (CLK_EN) begin
			flags_reg[0] <= (mode_next == ascpm_pkg::PWR_NORMAL);
			flags_reg[1] <= (mode_next == ascpm_pkg::PWR_QUICK_SLEEP);
			flags_reg[2] <= (mode_next == ascpm_pkg::PWR_LOW_CURRENT);
			flags_reg[3] <= (mode_next == ascpm_pkg::PWR_DEEP_SLEEP);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			start_pulse_reg <= 1'b0;
			done_pulse_reg  <= 1'b0;
		end else if (CLK_EN) begin
			start_pulse_reg <= start_rise;
			done_pulse_reg  <= done_rise;
		end
	end

	assign POWER_MODE       = mode_reg;
	assign CHANNEL_CONFIG   = cfg_reg;
	assign FULL_POWER       = flags_reg[0];
	assign QUICK_SLEEP      = flags_reg[1];
	assign LOW_CURRENT_IDLE = flags_reg[2];
	assign DEEP_SLEEP       = flags_reg[3];
	assign CONVERTING       = converting_reg;
	assign CONV_START       = start_pulse_reg;
	assign CONV_DONE        = done_pulse_reg;

endmodule

/* ascpm_pkg.sv */
package ascpm_pkg;

	// ----------------------------------------
	// clocking and serial rates
	// ----------------------------------------
	localparam int unsigned SYS_CLK_HZ         = 25_000_000;
	localparam int unsigned SYS_CLK_MHZ        = 25;
	localparam int unsigned SCLK_TARGET_HZ     = 4_000_000;
	localparam int unsigned SCLK_LOWPWR_MAX_HZ = 4_800_000;
	// half period rounds up so the clock never exceeds its target
	localparam int unsigned SCLK_HALF_CYCLES   = (SYS_CLK_HZ + 2 * SCLK_TARGET_HZ - 1) / (2 * SCLK_TARGET_HZ);
	localparam int unsigned CS_SETUP_NS        = 200;
	localparam int unsigned CS_SETUP_CYCLES    = (CS_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned CS_GAP_NS          = 400;
	localparam int unsigned CS_GAP_CYCLES      = (CS_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int unsigned HOST_TIMEOUT_EDGES = 32;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int unsigned CTRL_BITS      = 8;
	localparam int unsigned CFG_BITS       = 5;
	localparam int unsigned RESULT_BITS    = 12;
	localparam int unsigned TRAIL_BITS     = 4;
	localparam int unsigned READ_BITS      = 16;
	localparam int unsigned CTRL_START_POS = 7;
	localparam int unsigned CTRL_CFG_LSB   = 2;
	localparam int unsigned CTRL_PDH_POS   = 1;
	localparam int unsigned CTRL_PDL_POS   = 0;

	// ----------------------------------------
	// power modes and reset values
	// ----------------------------------------
	localparam logic [1:0] PWR_DEEP_SLEEP  = 2'h0;
	localparam logic [1:0] PWR_QUICK_SLEEP = 2'h1;
	localparam logic [1:0] PWR_LOW_CURRENT = 2'h2;
	localparam logic [1:0] PWR_NORMAL      = 2'h3;
	localparam logic [1:0] PWR_RESET       = PWR_NORMAL;
	localparam logic [4:0] CFG_RESET       = 5'h00;

endpackage

/* ascpm_if.sv */
`timescale 1ns/1ps
interface ascpm_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic strobe;
	logic strobe_oe_n;
	logic dout_line;
	logic strobe_line;

	// undriven lines read low
	assign dout_line   = !dout_oe_n & dout;
	assign strobe_line = !strobe_oe_n & strobe;

	modport device (
		input  cs_n,
		input  sclk,
		input  din,
		output dout,
		output dout_oe_n,
		output strobe,
		output strobe_oe_n
	);

	modport host (
		output cs_n,
		output sclk,
		output din,
		input  dout_line,
		input  strobe_line
	);
endinterface

/* ascpm_sync.sv */
`timescale 1ns/1ps
module ascpm_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] mid_reg;
	logic [W-1:0] late_reg;
	logic [W-1:0] q_reg;

	// a bit changes once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= INIT;
			mid_reg  <= INIT;
			late_reg <= INIT;
			q_reg    <= INIT;
		end else if (clk_en) begin
			meta_reg <= d;
			mid_reg  <= meta_reg;
			late_reg <= mid_reg;
			q_reg    <= (~(mid_reg ^ late_reg) & late_reg) | ((mid_reg ^ late_reg) & q_reg);
		end
	end

	assign q = q_reg;
endmodule

/* ascpm_host.sv */
`timescale 1ns/1ps
module ascpm_host #(
	parameter int unsigned HALF_CYCLES = ascpm_pkg::SCLK_HALF_CYCLES,
	parameter int unsigned SETUP_CYCLES = ascpm_pkg::CS_SETUP_CYCLES,
	parameter int unsigned GAP_CYCLES   = ascpm_pkg::CS_GAP_CYCLES
) (
	input  wire logic                          SYS_CLK,
	input  wire logic                          RST_N,
	input  wire logic                          CLK_EN,
	input  wire logic                          CMD_VALID,
	output logic                               CMD_READY,
	input  wire logic [ascpm_pkg::CFG_BITS-1:0] CMD_CONFIG,
	input  wire logic [1:0]                    CMD_POWER,
	output logic                               RESULT_VALID,
	output logic      [ascpm_pkg::RESULT_BITS-1:0] RESULT_DATA,
	output logic                               TIMEOUT,
	ascpm_if.host                              LINK
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_SETUP = 4'h2,
		H_CLOCK = 4'h4,
		H_GAP   = 4'h8
	} ascpm_host_t;

	ascpm_host_t                      state_reg;
	logic [7:0]                       tmr_reg;
	logic [7:0]                       half_reg;
	logic                             sclk_reg;
	logic                             cs_n_reg;
	logic                             din_reg;
	logic [ascpm_pkg::CTRL_BITS-1:0]  tx_reg;
	logic [ascpm_pkg::READ_BITS-1:0]  rx_reg;
	logic [ascpm_pkg::READ_BITS-1:0]  rx_word;
	logic [4:0]                       rx_cnt_reg;
	logic                             rx_on_reg;
	logic [5:0]                       edge_cnt_reg;
	logic                             strobe_prev_reg;
	logic [ascpm_pkg::RESULT_BITS-1:0] result_reg;
	logic                             valid_reg;
	logic                             timeout_reg;
	logic [1:0]                       pin_s;
	logic                             half_end;
	logic                             sample_pt;

	// ----------------------------------------
	// returning pins, three stages
	// ----------------------------------------
	ascpm_sync #(
		.W    (2),
		.INIT (2'h0)
	) u_sync (
		.clk    (SYS_CLK),
		.rst_n  (RST_N),
		.clk_en (CLK_EN),
		.d      ({LINK.strobe_line, LINK.dout_line}),
		.q      (pin_s)
	);

	assign half_end  = (half_reg == 8'(HALF_CYCLES - 1));
	// last cycle of the high phase, data stable since the previous fall
	assign sample_pt = (state_reg == H_CLOCK) && sclk_reg && half_end;
	assign rx_word   = {rx_reg[ascpm_pkg::READ_BITS-2:0], pin_s[0]};

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_reg       <= H_IDLE;
			tmr_reg         <= 8'h00;
			half_reg        <= 8'h00;
			sclk_reg        <= 1'b0;
			cs_n_reg        <= 1'b1;
			din_reg         <= 1'b0;
			tx_reg          <= 8'h00;
			rx_reg          <= 16'h0000;
			rx_cnt_reg      <= 5'h00;
			rx_on_reg       <= 1'b0;
			edge_cnt_reg    <= 6'h00;
			strobe_prev_reg <= 1'b0;
			result_reg      <= 12'h000;
			valid_reg       <= 1'b0;
			timeout_reg     <= 1'b0;
		end else if (CLK_EN) begin
			valid_reg   <= 1'b0;
			timeout_reg <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (CMD_VALID) begin
						tx_reg       <= {CMD_CONFIG, CMD_POWER, 1'b0};
						din_reg      <= 1'b1;
						cs_n_reg     <= 1'b0;
						tmr_reg      <= 8'h00;
						rx_on_reg    <= 1'b0;
						rx_cnt_reg   <= 5'h00;
						edge_cnt_reg <= 6'h00;
						state_reg    <= H_SETUP;
					end
				end
				H_SETUP: begin
					tmr_reg <= tmr_reg + 8'h01;
					if (tmr_reg == 8'(SETUP_CYCLES - 1)) begin
						half_reg        <= 8'h00;
						strobe_prev_reg <= 1'b0;
						state_reg       <= H_CLOCK;
					end
				end
				H_CLOCK: begin
					half_reg <= half_end ? 8'h00 : half_reg + 8'h01;
					if (half_end) begin
						sclk_reg <= ~sclk_reg;
					end
					if (half_end && sclk_reg) begin
						din_reg <= tx_reg[ascpm_pkg::CTRL_BITS-1];
						tx_reg  <= {tx_reg[ascpm_pkg::CTRL_BITS-2:0], 1'b0};
					end
					if (sample_pt) begin
						edge_cnt_reg    <= edge_cnt_reg + 6'h01;
						strobe_prev_reg <= pin_s[1];
						if (rx_on_reg || (strobe_prev_reg && !pin_s[1])) begin
							rx_on_reg  <= 1'b1;
							rx_reg     <= rx_word;
							rx_cnt_reg <= rx_cnt_reg + 5'h01;
							if (rx_cnt_reg == 5'(ascpm_pkg::READ_BITS - 1)) begin
								result_reg <= rx_word[ascpm_pkg::READ_BITS-1 -: ascpm_pkg::RESULT_BITS];
								valid_reg  <= 1'b1;
								cs_n_reg   <= 1'b1;
								tmr_reg    <= 8'h00;
								state_reg  <= H_GAP;
							end
						end else if (edge_cnt_reg == 6'(ascpm_pkg::HOST_TIMEOUT_EDGES - 1)) begin
							timeout_reg <= 1'b1;
							cs_n_reg    <= 1'b1;
							tmr_reg     <= 8'h00;
							state_reg   <= H_GAP;
						end
					end
				end
				H_GAP: begin
					din_reg  <= 1'b0;
					sclk_reg <= 1'b0;
					tmr_reg  <= tmr_reg + 8'h01;
					if (tmr_reg == 8'(GAP_CYCLES - 1)) begin
						state_reg <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign CMD_READY    = (state_reg == H_IDLE);
	assign RESULT_VALID = valid_reg;
	assign RESULT_DATA  = result_reg;
	assign TIMEOUT      = timeout_reg;
	assign LINK.cs_n    = cs_n_reg;
	assign LINK.sclk    = sclk_reg;
	assign LINK.din     = din_reg;

endmodule

/* ascpm_link_assertions.sv */
`timescale 1ns/1ps
module ascpm_link_assertions (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout_oe_n,
	input wire logic strobe_oe_n,
	input wire logic dout_line,
	input wire logic strobe_line
);
	logic [4:0] rise_cnt_reg;
	logic [4:0] rise_cnt_next;

	// ----------------------------------------
	// rises seen in the current frame
	// ----------------------------------------
	assign rise_cnt_next = rise_cnt_reg + 5'h01;

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			rise_cnt_reg <= 5'h00;
		end else begin
			rise_cnt_reg <= rise_cnt_next;
		end
	end

	// ----------------------------------------
	// link checks
	// ----------------------------------------
	AST_START_BIT: assert property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg == 5'h00 |-> din)
		else $error("start bit missing");
	AST_STROBE_HIGH: assert property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg == 5'h08 |-> strobe_line)
		else $error("strobe not high after control byte");
	AST_STROBE_LOW: assert property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg != 5'h08 |-> !strobe_line)
		else $error("strobe high outside its period");
	AST_TRAIL_ZERO: assert property (@(posedge sclk) disable iff (cs_n)
		rise_cnt_reg inside {[5'h15:5'h18]} |-> !dout_line)
		else $error("trailing bit not zero");
	AST_FRAME_LEN: assert property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg <= 5'h18)
		else $error("too many clocks in frame");
	AST_RELEASE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		dout_oe_n == cs_n && strobe_oe_n == cs_n)
		else $error("outputs driven outside frame");
	AST_CS_FIRST: assert property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(sclk) |-> !cs_n && !$past(cs_n))
		else $error("clock before chip select");
	AST_CLK_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RST_N) cs_n && $past(cs_n) |-> !sclk)
		else $error("clock not idle low");
	AST_CLK_HIGH: assert property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(sclk) |-> sclk[*3])
		else $error("clock high phase too short");
	AST_CLK_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N) $fell(sclk) |-> (!sclk)[*3])
		else $error("clock low phase too short");
	AST_DIN_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!cs_n && sclk && $past(sclk) |-> $stable(din))
		else $error("data changed while clock high");
	AST_CS_END: assert property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(cs_n) |-> $past(rise_cnt_reg) == 5'h19)
		else $error("frame ended early");

	cover property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg == 5'h08 && strobe_line);
	cover property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg == 5'h18);
	cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(cs_n));
endmodule

/* test_adc_serial_power_mode_control.sv */
`timescale 1ns/1ps
module test_adc_serial_power_mode_control;
	typedef struct packed {
		logic [11:0] res;
		logic [4:0]  cfg;
		logic [1:0]  pwr;
	} ascpm_exp_t;
	logic        sys_clk;
	logic        rst_n;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [4:0]  cmd_config;
	logic [1:0]  cmd_power;
	logic [11:0] sample_data;
	logic [1:0]  power_mode;
	logic [4:0]  channel_config;
	logic        full_power;
	logic        quick_sleep;
	logic        low_current_idle;
	logic        deep_sleep;
	logic        conv_start;
	logic        conv_done;
	logic        converting;
	logic        done_seen;
	logic        result_valid;
	logic        timeout;
	logic [11:0] result_data;
	logic [24:0] dout_bits;
	logic [24:0] din_bits;
	logic [1:0]  last_pwr;
	ascpm_exp_t  exp_q[$];
	ascpm_exp_t  cur;
	integer      seed;
	int          miscompares;
	int          samples_checked;
	int          cycles;

	ascpm_if ascpm_if_inst ();
	ascpm_device ascpm_device_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1), .SAMPLE_DATA(sample_data),
		.LINK(ascpm_if_inst), .POWER_MODE(power_mode), .CHANNEL_CONFIG(channel_config), .FULL_POWER(full_power),
		.QUICK_SLEEP(quick_sleep), .LOW_CURRENT_IDLE(low_current_idle), .DEEP_SLEEP(deep_sleep),
		.CONVERTING(converting),
		.CONV_START(conv_start), .CONV_DONE(conv_done));
	ascpm_host ascpm_host_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .CMD_CONFIG(cmd_config), .CMD_POWER(cmd_power), .RESULT_VALID(result_valid),
		.RESULT_DATA(result_data), .TIMEOUT(timeout), .LINK(ascpm_if_inst));
	ascpm_link_assertions ascpm_link_assertions_inst (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.cs_n(ascpm_if_inst.cs_n), .sclk(ascpm_if_inst.sclk), .din(ascpm_if_inst.din),
		.dout_oe_n(ascpm_if_inst.dout_oe_n), .strobe_oe_n(ascpm_if_inst.strobe_oe_n),
		.dout_line(ascpm_if_inst.dout_line), .strobe_line(ascpm_if_inst.strobe_line));

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task chk_mode(input logic [1:0] exp);
		chk_val({10'h000, power_mode, full_power, low_current_idle, quick_sleep, deep_sleep},
			{10'h000, exp, exp == ascpm_pkg::PWR_NORMAL, exp == ascpm_pkg::PWR_LOW_CURRENT,
			exp == ascpm_pkg::PWR_QUICK_SLEEP, exp == ascpm_pkg::PWR_DEEP_SLEEP});
	endtask

	task end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task run_cmd(input logic [1:0] pwr, input logic [11:0] smp);
		int         n;
		logic [4:0] cfg;
		cfg = 5'($random(seed));
		chk_mode(last_pwr);
		sample_data <= smp;
		repeat (6) @(posedge sys_clk);
		cmd_config <= cfg;
		cmd_power <= pwr;
		cmd_valid <= 1'b1;
		exp_q.push_back({smp, cfg, pwr});
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 800);
		if (n >= 800) begin
			chk_val({15'h0000, cmd_ready}, 16'h0001);
		end
		@(posedge sys_clk);
		last_pwr = pwr;
		$display("test done mode %0h sample %0h", pwr, smp);
	endtask

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_config = 5'h00;
		cmd_power = 2'h0;
		sample_data = 12'h000;
		done_seen = 1'b0;
		last_pwr = ascpm_pkg::PWR_RESET;
		seed = 32'h269A;
		miscompares = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		run_cmd(ascpm_pkg::PWR_QUICK_SLEEP, 12'h000);
		run_cmd(ascpm_pkg::PWR_LOW_CURRENT, 12'hFFF);
		run_cmd(ascpm_pkg::PWR_DEEP_SLEEP, 12'h800);
		run_cmd(ascpm_pkg::PWR_NORMAL, 12'h001);
		for (int i = 0; i < 8; i++) begin
			run_cmd(2'($random(seed)), 12'($random(seed)));
		end
		end_of_test();
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// monitors
	// ----------------------------------------
	always @(negedge sys_clk) begin
		if (conv_start === 1'b1) begin
			chk_mode(ascpm_pkg::PWR_NORMAL);
			chk_val({15'h0000, converting}, 16'h0001);
		end
		if (conv_done === 1'b1) begin
			done_seen = 1'b1;
			chk_val({15'h0000, converting}, 16'h0000);
		end
		if (rst_n === 1'b1 && timeout !== 1'b0) begin
			chk_val({15'h0000, timeout}, 16'h0000);
		end
		if (result_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk_val(16'h0001, 16'h0000);
			end else begin
				cur = exp_q.pop_front();
				chk_val({4'h0, result_data}, {4'h0, cur.res});
				chk_mode(cur.pwr);
				chk_val({11'h000, channel_config}, {11'h000, cur.cfg});
				chk_val({15'h0000, done_seen}, 16'h0001);
				done_seen = 1'b0;
			end
		end
	end

	always @(posedge ascpm_if_inst.sclk) begin
		if (ascpm_if_inst.cs_n === 1'b0) begin
			dout_bits <= {dout_bits[23:0], ascpm_if_inst.dout_line};
			din_bits <= {din_bits[23:0], ascpm_if_inst.din};
		end
	end

	always @(posedge ascpm_if_inst.cs_n) begin
		if (rst_n === 1'b1 && exp_q.size() > 0) begin
			chk_val(dout_bits[15:0], {exp_q[0].res, 4'h0});
			chk_val({8'h00, din_bits[24:17]}, {8'h00, 1'b1, exp_q[0].cfg, exp_q[0].pwr});
		end
	end
endmodule
